/* File: src/sspf_pkg.sv */
package sspf_pkg;

  // ==========================================================================
  // geometry
  localparam int WORD_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int PM_W   = 8;
  localparam int DC_W   = 5;
  localparam int FIXED_PRESCALE = 8;

  // ==========================================================================
  // register offsets (word index on the register port)
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTLB   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RXDATA = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 3'h5;

  // ==========================================================================
  // field layouts, bit 0 is the last member
  typedef struct packed {
    logic rx_int;
    logic tx_int;
    logic flag1_en;
    logic flag0_en;
    logic flag1_direction;
    logic flag0_direction;
    logic lsb_first_select;
    logic sync_active_low;
    logic early_word_sync;
    logic bit_length_sync_select;
    logic mixed_sync_length;
    logic common_clocking_select;
  } sspf_ctrl_type;

  typedef struct packed {
    logic            fixed_div8;
    logic [DC_W-1:0] frame_rate;
    logic [PM_W-1:0] prescale;
  } sspf_clkdiv_type;

  typedef struct packed {
    logic tx_req_en;
    logic rx_req_en;
    logic out_flag1;
    logic out_flag0;
  } sspf_ctlb_type;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic in_flag1;
    logic in_flag0;
  } sspf_status_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sspf_bus_req_type;

  // ==========================================================================
  // reset values
  localparam sspf_ctrl_type   CTRL_RST   = 12'h000;
  localparam sspf_clkdiv_type CLKDIV_RST = 14'h0000;
  localparam sspf_ctlb_type   CTLB_RST   = 4'h0;

endpackage

/* File: src/sspf_port.sv */
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module sspf_port
  import sspf_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   resetn_i,
  // register port
  input  wire sspf_bus_req_type       bus_req_i,
  output logic [DATA_W-1:0]           bus_rdata_o,
  // transmit clock and sync pins
  input  wire logic                   tx_sck_i,
  output logic                        tx_sck_o,
  output logic                        tx_sck_oe_n_o,
  input  wire logic                   tx_fs_i,
  output logic                        tx_fs_o,
  output logic                        tx_fs_oe_n_o,
  // receive clock and sync pins
  input  wire logic                   rx_sck_i,
  input  wire logic                   rx_fs_i,
  // data pins
  input  wire logic                   rxd_i,
  output logic                        txd_o,
  output logic                        txd_oe_n_o,
  // flag pins
  input  wire logic [1:0]             serial_ctl_pin_i,
  output logic [1:0]                  serial_ctl_pin_o,
  output logic [1:0]                  serial_ctl_pin_oe_n_o,
  // service requests
  output logic                        rx_req_o,
  output logic                        tx_req_o
);

  localparam int FR_W = $clog2((2 ** DC_W) * WORD_W);
  localparam int CNT_W = $clog2(WORD_W);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);

  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SEND} sspf_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_RECV} sspf_rx_state_type;

  sspf_ctrl_type     ctrl_reg;
  sspf_clkdiv_type   clkdiv_reg;
  sspf_ctlb_type     ctlb_reg;
  sspf_status_type   status_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [WORD_W-1:0] rx_data_reg;
  logic [WORD_W-1:0] tx_data_reg;

  // ==========================================================================
  // synchronisers: 0 tx clock, 1 tx sync, 2 rx clock, 3 rx sync
  logic [3:0] ext_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;

  assign ext_raw = {rx_fs_i, rx_sck_i, tx_fs_i, tx_sck_i};

  for (genvar g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        sync3_reg[g] <= 1'b0;
      end
      else
      begin
        sync1_reg[g] <= ext_raw[g];
        sync2_reg[g] <= sync1_reg[g];
        sync3_reg[g] <= sync2_reg[g];
      end
    end
  end

  // ==========================================================================
  // format selection
  logic common;
  logic tx_bitlen;
  logic rx_look;
  logic tx_look;
  logic pol;

  assign common    = ctrl_reg.common_clocking_select;
  assign pol       = ctrl_reg.sync_active_low;
  assign tx_bitlen = ctrl_reg.bit_length_sync_select ^ (ctrl_reg.mixed_sync_length & ~common);
  // a look-ahead sync announces the word one bit early
  assign rx_look   = ctrl_reg.bit_length_sync_select | ctrl_reg.early_word_sync;
  assign tx_look   = tx_bitlen | ctrl_reg.early_word_sync;

  // ==========================================================================
  // internal clock generator
  logic [2:0]      pre_cnt_reg;
  logic [PM_W-1:0] div_cnt_reg;
  logic            gen_sck_reg;
  logic [FR_W-1:0] fr_cnt_reg;
  logic            gen_fs_reg;
  logic            pre_tick;
  logic            div_tick;
  logic            gen_rise;
  logic            gen_fall;
  logic [FR_W-1:0] fr_last;
  logic [FR_W-1:0] fr_next;
  logic            gen_fs_next;

  assign pre_tick = clkdiv_reg.fixed_div8 ? (pre_cnt_reg == 3'(FIXED_PRESCALE - 1)) : 1'b1;
  assign div_tick = pre_tick && (div_cnt_reg == clkdiv_reg.prescale);
  assign gen_rise = div_tick && !gen_sck_reg;
  assign gen_fall = div_tick && gen_sck_reg;
  assign fr_last  = FR_W'((int'(clkdiv_reg.frame_rate) + 1) * WORD_W - 1);
  assign fr_next  = (fr_cnt_reg == fr_last) ? '0 : fr_cnt_reg + 1'b1;

  // sync level for the bit slot that starts at the next rising edge
  always_comb
  begin
    if (tx_bitlen)
      gen_fs_next = (fr_next == fr_last);
    else if (ctrl_reg.early_word_sync)
      gen_fs_next = (fr_next == fr_last) || (fr_next < FR_W'(WORD_W - 1));
    else
      gen_fs_next = (fr_next < FR_W'(WORD_W));
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pre_cnt_reg <= 3'h0;
      div_cnt_reg <= '0;
      gen_sck_reg <= 1'b0;
      fr_cnt_reg  <= '0;
      gen_fs_reg  <= 1'b0;
    end
    else
    begin
      pre_cnt_reg <= pre_tick ? 3'h0 : pre_cnt_reg + 3'h1;
      if (pre_tick)
        div_cnt_reg <= div_tick ? '0 : div_cnt_reg + 1'b1;
      if (div_tick)
        gen_sck_reg <= !gen_sck_reg;
      if (gen_rise)
      begin
        fr_cnt_reg <= fr_next;
        gen_fs_reg <= gen_fs_next;
      end
    end
  end

  assign tx_sck_o      = gen_sck_reg;
  assign tx_fs_o       = gen_fs_reg ^ pol;
  assign tx_sck_oe_n_o = !ctrl_reg.tx_int;
  assign tx_fs_oe_n_o  = !ctrl_reg.tx_int;

  // ==========================================================================
  // clock and sync routing per section
  logic rx_int_eff;
  logic tx_rise;
  logic rx_fall;
  logic tx_fs_act;
  logic rx_fs_act;

  assign tx_rise    = ctrl_reg.tx_int ? gen_rise : (sync2_reg[0] && !sync3_reg[0]);
  assign tx_fs_act  = ctrl_reg.tx_int ? gen_fs_next : (sync2_reg[1] ^ pol);
  // common clocking slaves the receiver to the transmit source
  assign rx_int_eff = common ? ctrl_reg.tx_int : ctrl_reg.rx_int;
  always_comb
  begin
    if (rx_int_eff)
    begin
      rx_fall   = gen_fall;
      rx_fs_act = gen_fs_reg;
    end
    else if (common)
    begin
      rx_fall   = !sync2_reg[0] && sync3_reg[0];
      rx_fs_act = sync2_reg[1] ^ pol;
    end
    else
    begin
      rx_fall   = !sync2_reg[2] && sync3_reg[2];
      rx_fs_act = sync2_reg[3] ^ pol;
    end
  end

  // ==========================================================================
  // transmitter
  sspf_tx_state_type tx_state_reg;
  logic [CNT_W-1:0]  tx_cnt_reg;
  logic [WORD_W-1:0] tx_sh_reg;
  logic              txd_reg;
  logic              tx_fs_prev_reg;
  logic [1:0]        flag_out_reg;
  logic              tx_edge;
  logic              tx_free;
  logic              tx_start;
  logic              tx_done;
  logic              lsb;

  assign lsb      = ctrl_reg.lsb_first_select;
  assign tx_edge  = tx_fs_act && !tx_fs_prev_reg;
  assign tx_done  = (tx_state_reg == TX_SEND) && (tx_cnt_reg == LAST_BIT);
  assign tx_free  = (tx_state_reg == TX_IDLE) || tx_done;
  assign tx_start = tx_rise && ((tx_state_reg == TX_ARMED) || (tx_free && tx_edge && !tx_look));

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tx_state_reg   <= TX_IDLE;
      tx_cnt_reg     <= '0;
      tx_sh_reg      <= '0;
      txd_reg        <= 1'b0;
      tx_fs_prev_reg <= 1'b0;
      flag_out_reg   <= 2'h0;
    end
    else if (tx_rise)
    begin
      tx_fs_prev_reg <= tx_fs_act;
      if (tx_start)
      begin
        tx_state_reg <= TX_SEND;
        tx_cnt_reg   <= '0;
        txd_reg      <= lsb ? tx_data_reg[0] : tx_data_reg[WORD_W-1];
        tx_sh_reg    <= lsb ? (tx_data_reg >> 1) : (tx_data_reg << 1);
        flag_out_reg <= {ctlb_reg.out_flag1, ctlb_reg.out_flag0};
      end
      else if (tx_free)
        tx_state_reg <= (tx_edge && tx_look) ? TX_ARMED : TX_IDLE;
      else if (tx_state_reg == TX_SEND)
      begin
        tx_cnt_reg <= tx_cnt_reg + 1'b1;
        txd_reg    <= lsb ? tx_sh_reg[0] : tx_sh_reg[WORD_W-1];
        tx_sh_reg  <= lsb ? (tx_sh_reg >> 1) : (tx_sh_reg << 1);
      end
    end
  end

  assign txd_o      = txd_reg;
  assign txd_oe_n_o = (tx_state_reg != TX_SEND);

  // ==========================================================================
  // receiver
  sspf_rx_state_type rx_state_reg;
  logic [CNT_W-1:0]  rx_cnt_reg;
  logic [WORD_W-1:0] rx_sh_reg;
  logic              rx_fs_prev_reg;
  logic [1:0]        in_latch_reg;
  logic [WORD_W-1:0] rx_sh_next;
  logic              rx_edge;
  logic              rx_first;
  logic              rx_done;

  assign rx_edge    = rx_fs_act && !rx_fs_prev_reg;
  assign rx_sh_next = lsb ? {rxd_i, rx_sh_reg[WORD_W-1:1]} : {rx_sh_reg[WORD_W-2:0], rxd_i};
  assign rx_first   = rx_fall && ((rx_state_reg == RX_ARMED) || ((rx_state_reg == RX_IDLE) && rx_edge && !rx_look));
  assign rx_done    = rx_fall && (rx_state_reg == RX_RECV) && (rx_cnt_reg == LAST_BIT);

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_state_reg   <= RX_IDLE;
      rx_cnt_reg     <= '0;
      rx_sh_reg      <= '0;
      rx_fs_prev_reg <= 1'b0;
      in_latch_reg   <= 2'h0;
    end
    else if (rx_fall)
    begin
      rx_fs_prev_reg <= rx_fs_act;
      if (rx_first)
      begin
        rx_state_reg <= RX_RECV;
        rx_cnt_reg   <= CNT_W'(1);
        rx_sh_reg    <= rx_sh_next;
        in_latch_reg <= serial_ctl_pin_i;
      end
      else if (rx_state_reg == RX_IDLE)
      begin
        if (rx_edge && rx_look)
          rx_state_reg <= RX_ARMED;
      end
      else if (rx_done)
      begin
        rx_sh_reg    <= rx_sh_next;
        rx_state_reg <= (rx_edge && rx_look) ? RX_ARMED : RX_IDLE;
      end
      else if (rx_edge)
        rx_state_reg <= RX_IDLE;
      else
      begin
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
        rx_sh_reg  <= rx_sh_next;
      end
    end
  end

  // ==========================================================================
  // flag pins
  logic [1:0] flag_out_en;

  assign flag_out_en = {ctrl_reg.flag1_en & ctrl_reg.flag1_direction,
                        ctrl_reg.flag0_en & ctrl_reg.flag0_direction} & {2{common}};
  assign serial_ctl_pin_o      = flag_out_reg;
  assign serial_ctl_pin_oe_n_o = ~flag_out_en;

  // ==========================================================================
  // register port
  logic wr_txdata;
  logic rd_rxdata;

  assign wr_txdata = bus_req_i.wr && (bus_req_i.addr == OFS_TXDATA);
  assign rd_rxdata = bus_req_i.rd && (bus_req_i.addr == OFS_RXDATA);

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_reg    <= CTRL_RST;
      clkdiv_reg  <= CLKDIV_RST;
      ctlb_reg    <= CTLB_RST;
      tx_data_reg <= '0;
    end
    else if (bus_req_i.wr)
    begin
      unique case (bus_req_i.addr)
        OFS_CTRL:   ctrl_reg    <= sspf_ctrl_type'(bus_req_i.wdata[$bits(sspf_ctrl_type)-1:0]);
        OFS_CLKDIV: clkdiv_reg  <= sspf_clkdiv_type'(bus_req_i.wdata[$bits(sspf_clkdiv_type)-1:0]);
        OFS_CTLB:   ctlb_reg    <= sspf_ctlb_type'(bus_req_i.wdata[$bits(sspf_ctlb_type)-1:0]);
        OFS_TXDATA: tx_data_reg <= bus_req_i.wdata[WORD_W-1:0];
        default:    ;
      endcase
    end
  end

  // status: hardware set wins over the clearing access in the same cycle
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_reg  <= '{tx_empty: 1'b1, rx_full: 1'b0, in_flag1: 1'b0, in_flag0: 1'b0};
      rx_data_reg <= '0;
    end
    else
    begin
      if (rx_done)
      begin
        rx_data_reg         <= rx_sh_next;
        status_reg.rx_full  <= 1'b1;
        status_reg.in_flag1 <= in_latch_reg[1];
        status_reg.in_flag0 <= in_latch_reg[0];
      end
      else if (rd_rxdata)
        status_reg.rx_full <= 1'b0;
      if (tx_start)
        status_reg.tx_empty <= 1'b1;
      else if (wr_txdata)
        status_reg.tx_empty <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= '0;
    else if (bus_req_i.rd)
    begin
      unique case (bus_req_i.addr)
        OFS_CTRL:   rdata_reg <= DATA_W'(ctrl_reg);
        OFS_CLKDIV: rdata_reg <= DATA_W'(clkdiv_reg);
        OFS_CTLB:   rdata_reg <= DATA_W'(ctlb_reg);
        OFS_STATUS: rdata_reg <= DATA_W'(status_reg);
        OFS_RXDATA: rdata_reg <= DATA_W'(rx_data_reg);
        OFS_TXDATA: rdata_reg <= DATA_W'(tx_data_reg);
        default:    rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  assign bus_rdata_o = rdata_reg;
  assign rx_req_o    = status_reg.rx_full & ctlb_reg.rx_req_en;
  assign tx_req_o    = status_reg.tx_empty & ctlb_reg.tx_req_en;

  // ==========================================================================
  // assertions
  property p_txd_gap_hiz;
    @(posedge core_clk_i) disable iff (!resetn_i)
      tx_rise && tx_done && !tx_start |=> txd_oe_n_o;
  endproperty
  a_txd_gap_hiz: assert property (p_txd_gap_hiz) else $error("txd driven in frame gap");

  property p_first_bit_order;
    @(posedge core_clk_i) disable iff (!resetn_i)
      tx_start |=> txd_o == (lsb ? $past(tx_data_reg[0]) : $past(tx_data_reg[WORD_W-1]));
  endproperty
  a_first_bit_order: assert property (p_first_bit_order) else $error("wrong first tx bit");

  property p_in_flag_copy;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rx_done |=> {status_reg.in_flag1, status_reg.in_flag0} == $past(in_latch_reg) && status_reg.rx_full;
  endproperty
  a_in_flag_copy: assert property (p_in_flag_copy) else $error("input flags not copied");

  property p_common_one_format;
    @(posedge core_clk_i) disable iff (!resetn_i)
      common |-> tx_look == rx_look;
  endproperty
  a_common_one_format: assert property (p_common_one_format) else $error("mixed length not ignored");

  property p_flags_need_common;
    @(posedge core_clk_i) disable iff (!resetn_i)
      !common |-> &serial_ctl_pin_oe_n_o;
  endproperty
  a_flags_need_common: assert property (p_flags_need_common) else $error("flag driven without common");

  sequence s_sending;
    (tx_state_reg == TX_SEND) && !tx_start;
  endsequence
  property p_out_flag_stable;
    @(posedge core_clk_i) disable iff (!resetn_i)
      s_sending ##1 s_sending |-> $stable(serial_ctl_pin_o);
  endproperty
  a_out_flag_stable: assert property (p_out_flag_stable) else $error("output flag moved mid word");

  property p_early_sync_drops;
    @(posedge core_clk_i) disable iff (!resetn_i)
      rx_fall && rx_state_reg == RX_RECV && rx_cnt_reg != LAST_BIT && rx_edge |=> rx_state_reg == RX_IDLE;
  endproperty
  a_early_sync_drops: assert property (p_early_sync_drops) else $error("sync inside frame accepted");

  property p_fs_pin_polarity;
    @(posedge core_clk_i) disable iff (!resetn_i)
      gen_rise ##1 !gen_rise |-> tx_fs_o == ($past(gen_fs_next) ^ pol);
  endproperty
  a_fs_pin_polarity: assert property (p_fs_pin_polarity) else $error("sync pin polarity wrong");

endmodule // sspf_port

/* File: verification/sspf_codec_model.sv */
`timescale 1ns/1ps

// ============================================================
// far-side codec: slave to the port's bit clock and frame sync
module sspf_codec_model
  import sspf_pkg::*;
(
  // link from the port
  input  wire logic              sck_i,
  input  wire logic              fs_i,
  input  wire logic              txd_i,
  input  wire logic              txd_oe_n_i,
  output logic                   rxd_o,
  // word format
  input  wire logic              lead_i,
  input  wire logic              lsb_i,
  input  wire logic              act_low_i,
  input  wire logic [WORD_W-1:0] rx_word_i,
  // captured results
  output logic [WORD_W-1:0]      word_o,
  output logic                   got_o,
  output logic [7:0]             sync_len_o
);
  int                slot = 99;
  int                nbits = 0;
  logic              fs_prev = 1'b0;
  logic [WORD_W-1:0] sh = '0;
  logic              fs_act;

  assign fs_act = fs_i ^ act_low_i;

  initial
  begin
    rxd_o = 1'b0;
    got_o = 1'b0;
    word_o = '0;
    sync_len_o = 8'h00;
  end

  // clock and sync leave the port on the same edge, so let both settle
  always @(posedge sck_i)
  begin
    #1;
    got_o <= 1'b0;
    if (fs_act && !fs_prev)
    begin
      slot = lead_i ? -1 : 0;
      sync_len_o <= 8'h01;
    end
    else
    begin
      slot = slot + 1;
      if (fs_act)
        sync_len_o <= sync_len_o + 8'h01;
    end
    fs_prev <= fs_act;
    if (slot >= 0 && slot < WORD_W)
      rxd_o <= rx_word_i[lsb_i ? slot : WORD_W-1-slot];
    else
      rxd_o <= ~rxd_o; // line toggles every bit slot between words
  end

  always @(negedge sck_i)
  begin
    if (!txd_oe_n_i)
    begin
      sh = lsb_i ? {txd_i, sh[WORD_W-1:1]} : {sh[WORD_W-2:0], txd_i};
      nbits = nbits + 1;
      if (nbits == WORD_W)
      begin
        word_o <= sh;
        got_o <= 1'b1;
        nbits = 0;
      end
    end
  end

  // a release mid-word (reset) must not leave a partial count
  always @(posedge txd_oe_n_i)
    nbits = 0;
endmodule // sspf_codec_model

/* File: verification/sspf_port_bench.sv */
`timescale 1ns/1ps

module sspf_port_bench
  import sspf_pkg::*;
;
  logic              core_clk;
  logic              resetn;
  sspf_bus_req_type  req;
  logic [DATA_W-1:0] rdata;
  logic              tx_sck;
  logic              tx_fs;
  logic              txd;
  logic              txd_oe_n;
  logic              rxd;
  logic              rx_req;
  logic              tx_req;
  logic [1:0]        pin_o;
  logic [1:0]        pin_oe_n;
  logic [1:0]        pin_i;
  logic [1:0]        clk_oe_n;
  logic              pin1;
  logic              lead;
  logic              lsb;
  logic              act_low;
  logic              got;
  logic              rd_d = 1'b0;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] word;
  logic [7:0]        sync_len;
  logic [31:0]       seed;
  logic [DATA_W-1:0] rd_q[$];
  logic [WORD_W-1:0] tx_q[$];
  int                miscompares = 0;
  int                checks_done = 0;
  int                words_seen = 0;
  // [5:0] mode bits, [8] sync leads the word, [9] one-slot sync
  logic [15:0]       modes [8] = '{16'h001, 16'h003, 16'h305, 16'h109, 16'h30d, 16'h031, 16'h302, 16'h000};

  // flag0 pin has a pull-up when released
  assign pin_i[0] = pin_oe_n[0] ? 1'b1 : pin_o[0];
  assign pin_i[1] = pin_oe_n[1] ? pin1 : pin_o[1];

  sspf_port sspf_port_inst (
    .core_clk_i(core_clk), .resetn_i(resetn), .bus_req_i(req), .bus_rdata_o(rdata),
    .tx_sck_i(1'b0), .tx_sck_o(tx_sck), .tx_sck_oe_n_o(clk_oe_n[0]), .tx_fs_i(1'b0), .tx_fs_o(tx_fs),
    .tx_fs_oe_n_o(clk_oe_n[1]), .rx_sck_i(tx_sck), .rx_fs_i(tx_fs), .rxd_i(rxd), .txd_o(txd),
    .txd_oe_n_o(txd_oe_n), .serial_ctl_pin_i(pin_i), .serial_ctl_pin_o(pin_o),
    .serial_ctl_pin_oe_n_o(pin_oe_n), .rx_req_o(rx_req), .tx_req_o(tx_req));

  sspf_codec_model sspf_codec_model_inst (
    .sck_i(tx_sck), .fs_i(tx_fs), .txd_i(txd), .txd_oe_n_i(txd_oe_n), .rxd_o(rxd),
    .lead_i(lead), .lsb_i(lsb), .act_low_i(act_low), .rx_word_i(rx_word),
    .word_o(word), .got_o(got), .sync_len_o(sync_len));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++)
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ============================================================
  // register port master
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    req <= '0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd_q.push_back(exp);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
  endtask

  task automatic rst();
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  task automatic wait_word();
    int start;
    start = words_seen;
    repeat (1000)
      if (words_seen == start) @(posedge core_clk);
    chk("word arrival", 16'h0001, {15'h0, words_seen != start});
  endtask

  // ============================================================
  // result monitors
  always @(posedge core_clk)
  begin
    if (rd_d && rd_q.size() > 0)
      chk("read data", rd_q.pop_front(), rdata);
    rd_d <= req.rd;
  end

  always @(posedge got)
  begin
    words_seen++;
    if (tx_q.size() > 0)
      chk("link word", tx_q.pop_front(), word);
  end

  // ============================================================
  // one frame format per call, two slots a frame, bit = 8 core cycles
  // receive pins loop back clock and sync; the synchronisers need a bit above 4 cycles
  task automatic run(input logic [15:0] m);
    logic [WORD_W-1:0] d;
    logic              v;
    logic              of0;
    seed = lfsr(seed);
    d = seed[15:0];
    rx_word <= seed[31:16];
    seed = lfsr(seed);
    v = seed[0];
    of0 = seed[1];
    rst();
    lead <= m[8];
    lsb <= m[5];
    act_low <= m[4];
    pin1 <= v;
    wr(OFS_CLKDIV, 16'h0103);
    wr(OFS_CTLB, {12'h000, 2'b11, 1'b0, of0});
    tx_q.push_back(d);
    tx_q.push_back(d);
    wr(OFS_TXDATA, d);
    // async runs clear the receive internal select and take the looped-back pins
    wr(OFS_CTRL, (m[0] ? 16'h0f40 : 16'h0740) | {10'h000, m[5:0]});
    wait_word();
    @(posedge txd_oe_n);
    @(negedge tx_sck iff !txd_oe_n);
    @(posedge core_clk);
    pin1 <= ~v;
    wait_word();
    repeat (6) @(posedge core_clk);
    chk("data enable", 16'h0001, {15'h0, txd_oe_n});
    chk("clock enables", 16'h0000, {14'h0, clk_oe_n});
    chk("sync length", m[9] ? 16'h0001 : 16'h0010, {8'h00, sync_len});
    if (m[0])
    begin
      chk("flag enables", 16'h0002, {14'h0, pin_oe_n});
      chk("out flag", {15'h0, of0}, {15'h0, pin_o[0]});
      chk("requests", 16'h0003, {14'h0, rx_req, tx_req});
      rd(OFS_STATUS, {12'h000, 2'b11, v, of0});
      rd(OFS_RXDATA, rx_word);
    end
    else
    begin
      chk("flag enables", 16'h0003, {14'h0, pin_oe_n});
      if (!m[1])
        rd(OFS_RXDATA, rx_word);
    end
    $display("test mode %h done", m);
  endtask

  initial
  begin
    req = '0;
    resetn = 1'b0;
    pin1 = 1'b0;
    lead = 1'b0;
    lsb = 1'b0;
    act_low = 1'b0;
    rx_word = '0;
    seed = 32'hfca4a5e0;
    rst();
    chk("clock enables", 16'h0003, {14'h0, clk_oe_n});
    rd(OFS_STATUS, 16'h0008);
    wr(3'h6, 16'hffff);
    rd(3'h6, 16'h0000);
    wr(OFS_CLKDIV, 16'hffff);
    rd(OFS_CLKDIV, 16'h3fff);
    wr(OFS_CTLB, 16'hffff);
    rd(OFS_CTLB, 16'h000f);
    $display("test registers done");
    foreach (modes[i])
      run(modes[i]);
    end_of_test();
  end

  // about thirteen times the expected run length
  initial
  begin
    #400000;
    miscompares++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule // sspf_port_bench
